/* File: sleep_wakeup_control.sv */
// sleep entry, wake-up and regulator-charge reset control
//
// The register offsets and the plain strobed port were left to the implementer.
`default_nettype none
module sleep_wakeup_control
    import swc_pkg::*;
#(
    parameter int STARTUP_COUNT = swc_pkg::STARTUP_PERIODS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clockEnable,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    input wire logic sleepInstr,
    input wire logic watchdogClearInstr,
    input wire logic [13:0] programCounter,
    input wire logic [7:0] periphIrqFlags,
    input wire logic [7:0] periphIrqEnables,
    input wire logic [2:0] coreIrqFlags,
    input wire logic [2:0] coreIrqEnables,
    input wire logic externalResetPin,
    input wire logic externalResetEnable,
    input wire logic brownoutReset,
    input wire logic brownoutEnable,
    input wire logic powerOnReset,
    input wire logic watchdogTimeout,
    input wire logic [1:0] watchdogMode,
    input wire logic crystalMode,
    input wire logic oscTick,
    input wire logic capCharged,
    input wire logic [1:0] regCapPinSelect,
    output logic deviceReset,
    output logic coreClockGate,
    output logic watchdogClear,
    output logic watchdogRunInSleep,
    output logic lowFreqOscRun,
    output logic timer1OscRun,
    output logic converterRcRun,
    output logic sensingOscRun,
    output logic ioHold,
    output logic resumeStrobe,
    output logic vectorStrobe,
    output logic [13:0] fetchAddr,
    output logic [2:0] capPinEnable
);
    import swc_pkg::*;

    // ==========================================
    // pin synchronisers
    logic [2:0] pinSync [5];
    logic [4:0] pinLevel;
    logic [4:0] pinRaw;
    assign pinRaw = {capCharged, watchdogTimeout, powerOnReset,
                     brownoutReset, externalResetPin};
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 5; i++)
                pinSync[i] <= 3'h0;
            pinLevel <= 5'h00;
        end
        else if (clockEnable)
        begin
            for (int i = 0; i < 5; i++)
            begin
                pinSync[i] <= {pinSync[i][1:0], pinRaw[i]};
                if (pinSync[i][1] == pinSync[i][2])
                    pinLevel[i] <= pinSync[i][2];
            end
        end
    end
    logic extResetIn, brownoutIn, porIn, watchdogIn, capIn;
    assign extResetIn = pinLevel[0];
    assign brownoutIn = pinLevel[1];
    assign porIn = pinLevel[2];
    assign watchdogIn = pinLevel[3];
    assign capIn = pinLevel[4];

    // ==========================================
    // registers
    logic [7:0] intControl;
    logic [7:0] wdControl;
    logic timeOutFlag;
    logic powerDownFlag;
    swc_state_type state;
    swc_state_type next_state;

    function automatic logic anyEnabled(input logic [7:0] pf,
                                        input logic [7:0] pe,
                                        input logic [2:0] cf,
                                        input logic [2:0] ce,
                                        input logic peripheral_irq_enable);
        anyEnabled = (|(cf & ce)) || (peripheral_irq_enable && |(pf & pe));
    endfunction

    logic irqPending;
    assign irqPending = anyEnabled(periphIrqFlags, periphIrqEnables,
                                   coreIrqFlags, coreIrqEnables,
                                   intControl[INT_PERIPH_EN]);

    logic resetWake;
    assign resetWake = (extResetIn && externalResetEnable) ||
                       (brownoutIn && brownoutEnable) || porIn;

    logic watchdogActiveSleep;
    always_comb
    begin
        case (watchdogMode)
            WDMODE_OFF: watchdogActiveSleep = 1'b0;
            WDMODE_SOFT: watchdogActiveSleep = wdControl[WDC_EN];
            WDMODE_NOSLEEP: watchdogActiveSleep = 1'b0;
            default: watchdogActiveSleep = 1'b1;
        endcase
    end

    logic sleepTaken;
    logic sleepNop;
    assign sleepTaken = (state == SWC_RUN) && sleepInstr && !irqPending;
    assign sleepNop = (state == SWC_RUN) && sleepInstr && irqPending;

    logic wakeEvent;
    assign wakeEvent = (state == SWC_SLEEP) &&
                       (irqPending || (watchdogIn && watchdogActiveSleep));

    logic startupDone;
    swc_startup_counter #(
        .PERIODS(STARTUP_COUNT)
    ) startupCounter (
        .clock(clock),
        .rst_n(rst_n),
        .enable(clockEnable),
        .start(wakeEvent && crystalMode),
        .oscTick(oscTick),
        .done(startupDone)
    );

    // ==========================================
    // state machine
    always_comb
    begin
        next_state = state;
        case (state)
            SWC_CHARGE: if (capIn || regCapPinSelect == CAP_NONE)
                next_state = SWC_RUN;
            SWC_RUN: if (sleepTaken)
                next_state = SWC_SLEEP;
            SWC_SLEEP: if (wakeEvent)
                next_state = crystalMode ? SWC_STARTWAIT : SWC_RUN;
            SWC_STARTWAIT: if (startupDone)
                next_state = SWC_RUN;
            default: next_state = SWC_CHARGE;
        endcase
        if (resetWake)
            next_state = SWC_CHARGE;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state <= SWC_CHARGE;
        else if (clockEnable)
            state <= next_state;
    end

    // ==========================================
    // status flags
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            timeOutFlag <= 1'b1;
            powerDownFlag <= 1'b1;
        end
        else if (clockEnable)
        begin
            if (sleepTaken)
            begin
                timeOutFlag <= 1'b1;
                powerDownFlag <= 1'b0;
            end
            else if (wakeEvent && watchdogIn && !irqPending)
                timeOutFlag <= 1'b0;
            else if (state == SWC_RUN && watchdogClearInstr)
            begin
                timeOutFlag <= 1'b1;
                powerDownFlag <= 1'b1;
            end
        end
    end

    // ==========================================
    // register port
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            intControl <= INTCTL_RESET;
            wdControl <= WDCTL_RESET;
        end
        else if (clockEnable && regWrite)
        begin
            if (regAddr == REG_INTCTL)
                intControl <= regWriteData;
            else if (regAddr == REG_WDCTL)
                wdControl <= {2'h0, regWriteData[5:0]};
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            regReadData <= 8'h00;
        else if (clockEnable)
        begin
            if (!regRead)
                regReadData <= 8'h00;
            else if (regAddr == REG_INTCTL)
                regReadData <= intControl;
            else if (regAddr == REG_STATUS)
                regReadData <= {3'h0, timeOutFlag, powerDownFlag, 3'h0};
            else if (regAddr == REG_WDCTL)
                regReadData <= wdControl;
            else
                regReadData <= {6'h00, regCapPinSelect};
        end
    end

    // ==========================================
    // outputs
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            deviceReset <= 1'b1;
            coreClockGate <= 1'b0;
            watchdogClear <= 1'b1;
            ioHold <= 1'b0;
            watchdogRunInSleep <= 1'b0;
        end
        else if (clockEnable)
        begin
            deviceReset <= (next_state == SWC_CHARGE);
            coreClockGate <= (next_state == SWC_SLEEP) ||
                             (next_state == SWC_STARTWAIT);
            watchdogClear <= sleepTaken || wakeEvent ||
                             (next_state == SWC_STARTWAIT) ||
                             (next_state == SWC_CHARGE) ||
                             (state == SWC_RUN && watchdogClearInstr);
            ioHold <= (next_state == SWC_SLEEP) ||
                      (next_state == SWC_STARTWAIT);
            watchdogRunInSleep <= watchdogActiveSleep;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            lowFreqOscRun <= 1'b0;
            timer1OscRun <= 1'b0;
            converterRcRun <= 1'b0;
            sensingOscRun <= 1'b0;
        end
        else if (clockEnable)
        begin
            lowFreqOscRun <= 1'b1;
            timer1OscRun <= 1'b1;
            converterRcRun <= 1'b1;
            sensingOscRun <= 1'b1;
        end
    end

    logic vectorPending;
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            fetchAddr <= 14'h0000;
            resumeStrobe <= 1'b0;
            vectorStrobe <= 1'b0;
            vectorPending <= 1'b0;
        end
        else if (clockEnable)
        begin
            resumeStrobe <= 1'b0;
            vectorStrobe <= 1'b0;
            if (sleepInstr && state == SWC_RUN)
                fetchAddr <= programCounter + 14'h0001;
            if (state != SWC_RUN && next_state == SWC_RUN &&
                state != SWC_CHARGE)
            begin
                resumeStrobe <= 1'b1;
                vectorPending <= intControl[INT_GLOBAL_EN] && irqPending;
            end
            else if (vectorPending)
            begin
                vectorPending <= 1'b0;
                vectorStrobe <= 1'b1;
                fetchAddr <= HANDLER_ADDR;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            capPinEnable <= 3'h0;
        else if (clockEnable)
        begin
            if (regCapPinSelect == CAP_PIN_ZERO)
                capPinEnable <= 3'h1;
            else if (regCapPinSelect == CAP_PIN_FIVE)
                capPinEnable <= 3'h2;
            else if (regCapPinSelect == CAP_PIN_SIX)
                capPinEnable <= 3'h4;
            else
                capPinEnable <= 3'h0;
        end
    end

    // ==========================================
    // checks
    sequence entrySeq;
        clockEnable && sleepTaken && !resetWake;
    endsequence

    chk_sleep_entry_flags: assert property (@(posedge clock) disable iff (!rst_n)
        entrySeq |=> !powerDownFlag && timeOutFlag)
        else $error("sleep entry flags wrong");
    chk_nop_keeps_flags: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && sleepNop && !watchdogClearInstr && !resetWake |=>
        $stable(powerDownFlag) && state == SWC_RUN)
        else $error("no-op sleep changed state");
    chk_gate_on_entry: assert property (@(posedge clock) disable iff (!rst_n)
        entrySeq |=> coreClockGate && ioHold && watchdogClear)
        else $error("gate not set on sleep");
    chk_only_sleep_instr: assert property (@(posedge clock) disable iff (!rst_n)
        state == SWC_RUN && !sleepInstr |=> state != SWC_SLEEP)
        else $error("sleep without instruction");
    chk_wake_clears_wdt: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && wakeEvent |=> watchdogClear)
        else $error("wake did not clear watchdog");
    chk_reset_wake: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && resetWake |=> deviceReset)
        else $error("reset wake missing");
    chk_fast_wake: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && wakeEvent && !crystalMode && !resetWake |=>
        !coreClockGate && resumeStrobe)
        else $error("non-crystal wake delayed");
    chk_prefetch_addr: assert property (@(posedge clock) disable iff (!rst_n)
        clockEnable && sleepInstr && state == SWC_RUN |=>
        fetchAddr == $past(programCounter) + 14'h0001)
        else $error("prefetch address wrong");
endmodule
`default_nettype wire

/* File: sleep_wakeup_control_test.sv */
// self-checking bench for the sleep and wake-up controller
`default_nettype none
module sleep_wakeup_control_test;
    import swc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] SLEEP_PC = 14'h0100;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWriteData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic doSleep = 1'b0;
    logic doClear = 1'b0;
    logic crystalMode = 1'b0;
    logic [7:0] periphIrqFlags = 8'h00;
    logic [7:0] periphIrqEnables = 8'h00;
    logic [2:0] coreIrqFlags = 3'h0;
    logic [2:0] coreIrqEnables = 3'h0;
    logic externalResetPin = 1'b0;
    logic externalResetEnable = 1'b1;
    logic watchdogTimeout = 1'b0;
    logic [1:0] watchdogMode = 2'h0;
    logic capCharged = 1'b0;
    logic [1:0] regCapPinSelect = 2'h0;
    logic [7:0] regReadData;
    logic sleepInstr, watchdogClearInstr, oscTick;
    logic deviceReset, coreClockGate, watchdogClear, watchdogRunInSleep;
    logic ioHold, resumeStrobe, vectorStrobe;
    logic [3:0] oscRun;
    logic [13:0] fetchAddr;
    logic [2:0] capPinEnable;
    int nErrors = 0;
    int samplesChecked = 0;

    sleep_wakeup_control #(.STARTUP_COUNT(4)) u_dut (
        .clock(clock), .rst_n(rst_n), .clockEnable(1'b1),
        .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
        .sleepInstr(sleepInstr), .watchdogClearInstr(watchdogClearInstr),
        .programCounter(SLEEP_PC), .periphIrqFlags(periphIrqFlags),
        .periphIrqEnables(periphIrqEnables), .coreIrqFlags(coreIrqFlags),
        .coreIrqEnables(coreIrqEnables),
        .externalResetPin(externalResetPin),
        .externalResetEnable(externalResetEnable),
        .brownoutReset(1'b0), .brownoutEnable(1'b0), .powerOnReset(1'b0),
        .watchdogTimeout(watchdogTimeout), .watchdogMode(watchdogMode),
        .crystalMode(crystalMode), .oscTick(oscTick),
        .capCharged(capCharged), .regCapPinSelect(regCapPinSelect),
        .deviceReset(deviceReset), .coreClockGate(coreClockGate),
        .watchdogClear(watchdogClear),
        .watchdogRunInSleep(watchdogRunInSleep),
        .lowFreqOscRun(oscRun[0]), .timer1OscRun(oscRun[1]),
        .converterRcRun(oscRun[2]), .sensingOscRun(oscRun[3]),
        .ioHold(ioHold), .resumeStrobe(resumeStrobe),
        .vectorStrobe(vectorStrobe), .fetchAddr(fetchAddr),
        .capPinEnable(capPinEnable)
    );
    swc_core_model u_core (
        .clock(clock), .doSleep(doSleep), .doClear(doClear),
        .tickRun(crystalMode), .sleepInstr(sleepInstr),
        .watchdogClearInstr(watchdogClearInstr), .oscTick(oscTick)
    );

    initial
    begin
        forever #5 clock = ~clock;
    end
    // ==========================================
    // compares and bus tasks
    task chkReg(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            nErrors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task chkSig(input logic [13:0] got, input logic [13:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            nErrors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task regWr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task regRd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        chkReg(regReadData, exp);
    endtask
    function automatic logic hit(input int which);
        case (which)
            0: return resumeStrobe === 1'b1;
            1: return deviceReset === 1'b0;
            default: return deviceReset === 1'b1;
        endcase
    endfunction
    task waitFor(input int which);
        int i;
        for (i = 0; i < 40 && !hit(which); i++)
        begin
            @(posedge clock);
            #1;
        end
        chkSig({13'h0, hit(which)}, 14'h1);
    endtask
    task sleepCmd;
        @(posedge clock);
        doSleep <= 1'b1;
        @(posedge clock);
        doSleep <= 1'b0;
        @(posedge clock);
        #1;
    endtask
    task clearWd;
        @(posedge clock);
        doClear <= 1'b1;
        @(posedge clock);
        doClear <= 1'b0;
        regRd(REG_STATUS, 8'h18);
    endtask
    task entryCheck;
        chkSig({7'h0, coreClockGate, ioHold, watchdogClear, oscRun}, 14'h7f);
        chkSig(fetchAddr, SLEEP_PC + 14'h1);
        regRd(REG_STATUS, 8'h10);
    endtask
    task summarize;
        $display("checked %0d, errors %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #100us;
        nErrors++;
        summarize();
    end
    // ==========================================
    // test sequence
    initial
    begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (10) @(posedge clock);
        #1;
        chkSig({13'h0, deviceReset}, 14'h1);
        @(posedge clock);
        capCharged <= 1'b1;
        waitFor(1);
        regRd(REG_INTCTL, INTCTL_RESET);
        regRd(REG_WDCTL, WDCTL_RESET);
        regWr(REG_STATUS, 8'h00);
        regRd(REG_STATUS, 8'h18);
        regWr(REG_WDCTL, 8'h2a);
        regRd(REG_WDCTL, 8'h2a);
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clock);
            regCapPinSelect <= 2'(s);
            repeat (3) @(posedge clock);
            #1;
            chkSig({11'h0, capPinEnable}, s == 3 ? 14'h0 : 14'(1 << s));
        end
        @(posedge clock);
        coreIrqFlags <= 3'h1;
        sleepCmd();
        entryCheck();
        repeat (5) @(posedge clock);
        coreIrqEnables <= 3'h1;
        #1;
        chkSig({13'h0, coreClockGate}, 14'h1);
        waitFor(0);
        chkSig({13'h0, coreClockGate}, 14'h0);
        @(posedge clock);
        #1;
        chkSig({13'h0, vectorStrobe}, 14'h0);
        clearWd();
        sleepCmd();
        chkSig({13'h0, coreClockGate}, 14'h0);
        regRd(REG_STATUS, 8'h18);
        regWr(REG_INTCTL, 8'h80);
        crystalMode <= 1'b1;
        coreIrqFlags <= 3'h0;
        sleepCmd();
        entryCheck();
        coreIrqFlags <= 3'h1;
        repeat (3) @(posedge clock);
        #1;
        chkSig({12'h0, coreClockGate, watchdogClear}, 14'h3);
        waitFor(0);
        chkSig({13'h0, coreClockGate}, 14'h0);
        @(posedge clock);
        coreIrqFlags <= 3'h0;
        crystalMode <= 1'b0;
        #1;
        chkSig({13'h0, vectorStrobe}, 14'h1);
        chkSig(fetchAddr, HANDLER_ADDR);
        regWr(REG_INTCTL, 8'h00);
        periphIrqFlags <= 8'h04;
        periphIrqEnables <= 8'h04;
        sleepCmd();
        entryCheck();
        repeat (5) @(posedge clock);
        #1;
        chkSig({13'h0, coreClockGate}, 14'h1);
        regWr(REG_INTCTL, 8'h40);
        waitFor(0);
        @(posedge clock);
        periphIrqFlags <= 8'h00;
        regWr(REG_INTCTL, 8'h00);
        watchdogMode <= WDMODE_NOSLEEP;
        sleepCmd();
        entryCheck();
        chkSig({13'h0, watchdogRunInSleep}, 14'h0);
        watchdogTimeout <= 1'b1;
        repeat (8) @(posedge clock);
        watchdogMode <= 2'h3;
        #1;
        chkSig({13'h0, coreClockGate}, 14'h1);
        waitFor(0);
        chkSig({13'h0, deviceReset}, 14'h0);
        regRd(REG_STATUS, 8'h00);
        watchdogTimeout <= 1'b0;
        clearWd();
        sleepCmd();
        entryCheck();
        chkSig({13'h0, watchdogRunInSleep}, 14'h1);
        externalResetPin <= 1'b1;
        waitFor(2);
        @(posedge clock);
        externalResetPin <= 1'b0;
        waitFor(1);
        summarize();
    end
endmodule
`default_nettype wire

/* File: swc_core_model.sv */
// partner model: core instruction issue and crystal tick source
`default_nettype none
module swc_core_model (
    input wire logic clock,
    input wire logic doSleep,
    input wire logic doClear,
    input wire logic tickRun,
    output logic sleepInstr,
    output logic watchdogClearInstr,
    output logic oscTick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] tickDiv;
    initial
    begin
        sleepInstr = 1'b0;
        watchdogClearInstr = 1'b0;
        oscTick = 1'b0;
        tickDiv = 2'h0;
    end
    // ==========================================
    // instruction issue, one per cycle
    always @(posedge clock)
    begin
        sleepInstr <= doSleep;
        watchdogClearInstr <= doClear;
    end
    // ==========================================
    // crystal divided by four, ticks only while it runs
    always @(posedge clock)
    begin
        tickDiv <= tickRun ? tickDiv + 2'h1 : 2'h0;
        oscTick <= tickRun && tickDiv == 2'h3;
    end
endmodule
`default_nettype wire

/* File: swc_ost_counter.sv */
// oscillator start-up timer counting oscillator periods
`default_nettype none
module swc_startup_counter #(
    parameter int PERIODS = 1024
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic start,
    input wire logic oscTick,
    output logic done
);
    logic [10:0] count;
    logic running;
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            count <= 11'h000;
            running <= 1'b0;
            done <= 1'b0;
        end
        else if (enable)
        begin
            done <= 1'b0;
            if (start)
            begin
                count <= 11'h000;
                running <= 1'b1;
            end
            else if (running && oscTick)
            begin
                if (count == 11'(PERIODS - 1))
                begin
                    running <= 1'b0;
                    done <= 1'b1;
                end
                else
                begin
                    count <= count + 11'h001;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: swc_pkg.sv */
// constants and types of the sleep and wake-up controller
// Functional notes
// - sleep is entered only on the core's sleep instruction
// - watchdog cleared on sleep entry, keeps counting if enabled in sleep
// - sleep entry clears power-down flag and sets time-out flag
// - core clock is stopped while asleep
// - low-frequency internal oscillator keeps running in sleep
// - timer1 oscillator keeps running in sleep
// - converter on its rc clock and sensing oscillator keep running
// - i/o ports hold their pre-sleep state during sleep
// - sleep does not change reset sources other than the watchdog
// - wake on reset pin, brown-out, power-on, watchdog or enabled interrupts
// - reset wakes reset the device; watchdog and interrupt wakes resume
// - instruction after sleep is prefetched while sleep executes
// - interrupt wakes only if individually enabled, regardless of global enable
// - global enable off resumes in line; on runs next then calls handler
// - with global enable on, an interrupt wake vectors to the fixed handler address
// - watchdog cleared on every wake from sleep
// - pending enabled interrupt makes sleep a no-op, flags untouched
// - interrupt during sleep completes sleep, wakes at once, flags updated
// - crystal modes wait 1024 oscillator periods on wake, others skip
// - device held in reset until regulator capacitor is charged
// - two-bit field picks cap pin among three port pins, 11 none
// - watchdog time-out in sleep wakes without reset, flags updated
// - peripheral interrupts act only when peripheral enable is set
`default_nettype none
package swc_pkg;
    localparam int STARTUP_PERIODS = 1024;
    localparam logic [13:0] HANDLER_ADDR = 14'h0004;
    localparam logic [1:0] REG_INTCTL = 2'h0;
    localparam logic [1:0] REG_STATUS = 2'h1;
    localparam logic [1:0] REG_WDCTL = 2'h2;
    localparam logic [1:0] REG_CAPSEL = 2'h3;
    localparam int INT_GLOBAL_EN = 7;
    localparam int INT_PERIPH_EN = 6;
    localparam int STS_TIMEOUT = 4;
    localparam int STS_POWERDOWN = 3;
    localparam int WDC_EN = 0;
    localparam logic [7:0] INTCTL_RESET = 8'h00;
    localparam logic [7:0] WDCTL_RESET = 8'h16;
    localparam logic [1:0] CAP_PIN_ZERO = 2'h0;
    localparam logic [1:0] CAP_PIN_FIVE = 2'h1;
    localparam logic [1:0] CAP_PIN_SIX = 2'h2;
    localparam logic [1:0] CAP_NONE = 2'h3;
    localparam logic [1:0] WDMODE_OFF = 2'h0;
    localparam logic [1:0] WDMODE_SOFT = 2'h1;
    localparam logic [1:0] WDMODE_NOSLEEP = 2'h2;
    typedef enum logic [1:0] {
        SWC_CHARGE = 2'h0,
        SWC_RUN = 2'h1,
        SWC_SLEEP = 2'h3,
        SWC_STARTWAIT = 2'h2
    } swc_state_type;
endpackage
`default_nettype wire
